/* common/rcc_pkg.sv */
// Constants, types and register map of the relative-mode and calibration command block.
// Assumes one 125 MHz clock and an APB master with 32-bit data.
`default_nettype none

package rcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_CMD      = 8'h00;
  localparam logic [7:0] OFS_CFG      = 8'h04;
  localparam logic [7:0] OFS_RESP     = 8'h08;
  localparam logic [7:0] OFS_ERR      = 8'h0C;
  localparam logic [7:0] OFS_STAT     = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_FACTOR   = 8'h1C;
  localparam logic [7:0] OFS_REF      = 8'h20;

  // Command word fields
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_SFX_LSB = 4;
  localparam int CMD_PRM_LSB = 6;
  localparam int CMD_QRY_BIT = 8;
  localparam int CMD_VAL_LSB = 16;

  // Configuration bits
  localparam int CFG_SPEED200 = 0;
  localparam int CFG_DUAL     = 1;
  localparam int CFG_EEPROM   = 2;

  // Sticky event bits
  localparam int IRQ_ERR  = 0;
  localparam int IRQ_RESP = 1;
  localparam int IRQ_DONE = 2;

  // Boolean-or-once parameter codes and suffix codes
  localparam logic [1:0] PRM_OFF  = 2'h0;
  localparam logic [1:0] PRM_ON   = 2'h1;
  localparam logic [1:0] PRM_ONCE = 2'h2;
  localparam logic [1:0] SFX_TWO  = 2'h2;

  // Error codes, two's complement
  localparam logic [15:0] ERR_CONFLICT = 16'hFF23;  // -221
  localparam logic [15:0] ERR_ILLEGAL  = 16'hFF20;  // -224
  localparam logic [15:0] ERR_QUEST    = 16'hFF19;  // -231
  localparam logic [15:0] ERR_SUFFIX   = 16'hFF8E;  // -114

  localparam logic [7:0] RCF_DEFAULT = 8'h64;       // 100 percent

  typedef enum logic [3:0] {
    OP_NOP       = 4'h0,
    OP_REL_AUTO  = 4'h1,
    OP_REL_STATE = 4'h2,
    OP_CAL_ALL   = 4'h3,
    OP_CAL_AUTO  = 4'h4,
    OP_CAL_ZERO  = 4'h5,
    OP_RCF       = 4'h6
  } rcc_op_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h1,
    SEQ_ZERO = 3'h2,
    SEQ_CAL  = 3'h4
  } rcc_seq_t;

  typedef logic [1:0][15:0] rcc_meas_t;
  typedef logic [1:0][7:0]  rcc_fac_t;

  typedef struct packed {
    logic req;
    logic zero;
    logic chan;
  } rcc_step_t;

  typedef struct packed {
    rcc_seq_t    seq;
    logic        chan;
    logic        query;
    logic        full;
    logic        ack_seen;
    logic        fail;
    logic        pend;
    rcc_step_t   step;
    logic [1:0]  rel_en;
    rcc_meas_t   ref_val;
    rcc_meas_t   meas_out;
    rcc_fac_t    rcf;
    logic [7:0]  cal_factor;
    logic [3:0]  cfg;
    logic        resp_valid;
    logic        resp_val;
    logic [15:0] err_code;
    logic        err_zero;
    logic        err_chb;
    logic        err_valid;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic        irq;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [1:0]  done_sync;
    logic [1:0]  fail_sync;
  } rcc_state_t;

  localparam rcc_state_t RCC_RESET = '{seq: SEQ_IDLE, rcf: {RCF_DEFAULT, RCF_DEFAULT},
                                       default: '0};

endpackage

`default_nettype wire

/* rtl/rcc_top.sv */
// Relative-mode and zero/calibration command block with an APB register slave.
// Assumes commands arrive as APB writes to the command register and that the
// analog step engine answers each step request with a four-phase done/fail.
//
// How it works
// - One-shot reference capture at speed 200 is refused with -221.
// - Capture with ON raises -224 and stores nothing.
// - Relative off passes measurement through; on subtracts the last reference.
// - Reset clears relative enable of both windows.
// - Relative state query answers 1 when enabled, 0 when disabled.
// - Switching relative on at speed 200 raises -221.
// - Calibration suffix 1 selects channel A, suffix 2 channel B.
// - Single-channel setting (CFG_DUAL clear) refuses suffix 2 on calibration and factor commands with header suffix error.
// - Calibration runs overlapped; commands keep being accepted meanwhile.
// - Full calibration zeroes first, then calibrates, same channel.
// - Full calibration query answers 0 pass, 1 fail; command form silent.
// - Calibration step failure raises -231 cal error naming channel.
// - Zeroing step failure raises -231 zero error naming channel.
// - Stand-alone calibration starts on ONCE, ignores OFF, ON gives -224.
// - Table-less sensors use the reference factor set most recently.
// - Sensors with on-board tables supply their own reference factor.
// - Capture stores processed value, enables relative, reads back OFF.
`default_nettype none

module rcc_top (
  input  wire logic               CORE_CLK,
  input  wire logic               RST_B,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [7:0]         PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  input  wire rcc_pkg::rcc_meas_t MEAS_IN,
  output rcc_pkg::rcc_meas_t      MEAS_OUT,
  input  wire logic [1:0]         TBL_LOAD,
  input  wire logic [7:0]         TBL_FACTOR,
  input  wire rcc_pkg::rcc_fac_t  EE_FACTOR,
  input  wire logic               STEP_DONE,
  input  wire logic               STEP_FAIL,
  output rcc_pkg::rcc_step_t      STEP,
  output logic      [7:0]         CAL_FACTOR,
  output logic                    OP_PENDING,
  output logic                    IRQ
);
  import rcc_pkg::*;

  rcc_state_t s;
  rcc_state_t n;
  // Command decode, visible to the checks below
  logic        cmd_wr;
  rcc_op_t     op;
  logic [1:0]  prm;
  logic        qry;
  logic        win;
  logic        c_err;
  logic [15:0] c_code;
  logic        done_s;
  logic        fail_s;
  logic        setup;
  logic        acc;
  logic        seq_err;
  logic        resp_ev;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    n      = s;
    setup  = PSEL & ~PENABLE & ~s.pready;
    acc    = PSEL & PENABLE & s.pready;
    cmd_wr = acc & PWRITE & (PADDR == OFS_CMD);
    op     = rcc_op_t'(PWDATA[CMD_OP_LSB +: 4]);
    prm    = PWDATA[CMD_PRM_LSB +: 2];
    qry    = PWDATA[CMD_QRY_BIT];
    win    = (PWDATA[CMD_SFX_LSB +: 2] == SFX_TWO);
    c_err  = 1'b0;
    c_code = '0;
    done_s = s.done_sync[1];
    fail_s = s.fail_sync[1];
    seq_err = 1'b0;
    resp_ev = 1'b0;

    // Step answer comes from the analog side, so it is synchronised first
    n.done_sync = {s.done_sync[0], STEP_DONE};
    n.fail_sync = {s.fail_sync[0], STEP_FAIL};

    // Zero-wait APB slave: answer prepared in the setup cycle
    n.pready  = setup;
    n.pslverr = 1'b0;
    if (setup) begin
      n.prdata = '0;
      if (PADDR == OFS_CMD) begin
        n.prdata = '0;
      end else if (PADDR == OFS_CFG) begin
        n.prdata[3:0] = s.cfg;
      end else if (PADDR == OFS_RESP) begin
        n.prdata[1:0] = {s.resp_valid, s.resp_val};
      end else if (PADDR == OFS_ERR) begin
        n.prdata = {s.err_valid, 13'h0000, s.err_chb, s.err_zero, s.err_code};
      end else if (PADDR == OFS_STAT) begin
        n.prdata[4:0] = {s.seq == SEQ_CAL, s.seq == SEQ_ZERO, s.rel_en, s.pend};
      end else if (PADDR == OFS_IRQ_STAT) begin
        n.prdata[2:0] = s.irq_stat;
      end else if (PADDR == OFS_IRQ_MASK) begin
        n.prdata[2:0] = s.irq_mask;
      end else if (PADDR == OFS_FACTOR) begin
        n.prdata[15:0] = s.rcf;
      end else if (PADDR == OFS_REF) begin
        n.prdata = s.ref_val;
      end else begin
        n.pslverr = PSEL;  // Unmapped address
      end
    end

    // Register writes and read side effects
    if (acc & PWRITE) begin
      if (PADDR == OFS_CFG) begin
        n.cfg = PWDATA[3:0];
      end else if (PADDR == OFS_IRQ_STAT) begin
        n.irq_stat = s.irq_stat & ~PWDATA[2:0];
      end else if (PADDR == OFS_IRQ_MASK) begin
        n.irq_mask = PWDATA[2:0];
      end
    end
    if (acc & ~PWRITE & (PADDR == OFS_RESP)) begin
      n.resp_valid = 1'b0;
    end
    if (acc & ~PWRITE & (PADDR == OFS_ERR)) begin
      n.err_valid = 1'b0;
    end

    // Reference factor from a newly enabled table; a manual write below wins a tie
    for (int c = 0; c < 2; c++) begin
      if (TBL_LOAD[c]) begin
        n.rcf[c] = TBL_FACTOR;
      end
    end

    // Command interpreter; it never waits on the sequencer
    // overlapped acceptance
    if (cmd_wr) begin
      if ((op == OP_CAL_ALL || op == OP_CAL_AUTO || op == OP_CAL_ZERO || op == OP_RCF)
          && win && !s.cfg[CFG_DUAL]) begin
        c_err  = 1'b1;
        c_code = ERR_SUFFIX;
      end else begin
        case (op)
          OP_REL_AUTO: begin
            if (qry) begin
              n.resp_valid = 1'b1;
              n.resp_val   = 1'b0;
              resp_ev      = 1'b1;
            end else if (prm == PRM_ON) begin
              c_err  = 1'b1;
              c_code = ERR_ILLEGAL;
            end else if (prm == PRM_ONCE && s.cfg[CFG_SPEED200]) begin
              c_err  = 1'b1;
              c_code = ERR_CONFLICT;
            end else if (prm == PRM_ONCE) begin
              n.ref_val[win] = MEAS_IN[win];
              n.rel_en[win]  = 1'b1;
            end
          end
          OP_REL_STATE: begin
            if (qry) begin
              n.resp_valid = 1'b1;
              n.resp_val   = s.rel_en[win];
              resp_ev      = 1'b1;
            end else if (prm == PRM_ON && s.cfg[CFG_SPEED200]) begin
              c_err  = 1'b1;
              c_code = ERR_CONFLICT;
            end else begin
              n.rel_en[win] = (prm == PRM_ON);
            end
          end
          OP_RCF: begin
            n.rcf[win] = PWDATA[CMD_VAL_LSB +: 8];
          end
          OP_CAL_ALL: begin
            if (s.seq == SEQ_IDLE) begin
              n.seq      = SEQ_ZERO;
              n.chan     = win;
              n.query    = qry;
              n.full     = 1'b1;
              n.ack_seen = 1'b0;
            end
          end
          OP_CAL_AUTO, OP_CAL_ZERO: begin
            if (qry) begin
              n.resp_valid = 1'b1;
              n.resp_val   = 1'b0;
              resp_ev      = 1'b1;
            end else if (prm == PRM_ON) begin
              c_err  = 1'b1;
              c_code = ERR_ILLEGAL;
            end else if (prm == PRM_ONCE && s.seq == SEQ_IDLE) begin
              n.seq      = (op == OP_CAL_ZERO) ? SEQ_ZERO : SEQ_CAL;
              n.chan     = win;
              n.query    = 1'b0;
              n.full     = 1'b0;
              n.ack_seen = 1'b0;
            end
          end
          default: begin
            n.seq = n.seq;
          end
        endcase
      end
    end
    if (c_err) begin
      n.err_valid = 1'b1;
      n.err_code  = c_code;
      n.err_zero  = 1'b0;
      n.err_chb   = 1'b0;
    end

    // Step sequencer, four-phase with the analog engine
    case (s.seq)
      SEQ_ZERO, SEQ_CAL: begin
        if (!s.ack_seen) begin
          if (s.step.req && done_s) begin
            n.ack_seen = 1'b1;
            n.step.req = 1'b0;
            n.fail     = fail_s;
          end else if (!done_s) begin
            // Waits for a stale done to drop before asking again
            n.step.req = 1'b1;
          end
        end else if (done_s) begin
          // Fail is read again while done stands, so skew between the
          // two synchronisers cannot hand over a stale pass or fail
          n.fail = fail_s;
        end else begin
          n.ack_seen = 1'b0;
          if (s.fail) begin
            // step failure report, sequencer outranks commands
            n.err_valid = 1'b1;
            n.err_code  = ERR_QUEST;
            seq_err     = 1'b1;
            n.err_zero  = (s.seq == SEQ_ZERO);
            n.err_chb   = s.chan & s.cfg[CFG_DUAL];
          end
          if (s.seq == SEQ_ZERO && s.full && !s.fail) begin
            n.seq = SEQ_CAL;
          end else begin
            n.seq               = SEQ_IDLE;
            n.irq_stat[IRQ_DONE] = 1'b1;
            if (s.query) begin
              n.resp_valid = 1'b1;
              n.resp_val   = s.fail;
              resp_ev      = 1'b1;
            end
          end
        end
      end
      default: begin
        n.step.req = 1'b0;
      end
    endcase
    n.step.zero = (n.seq == SEQ_ZERO);
    n.step.chan = n.chan;
    n.pend      = (n.seq != SEQ_IDLE);

    n.cal_factor = s.cfg[CFG_EEPROM + n.chan] ? EE_FACTOR[n.chan] : n.rcf[n.chan];

    for (int w = 0; w < 2; w++) begin
      n.meas_out[w] = s.rel_en[w] ? MEAS_IN[w] - s.ref_val[w] : MEAS_IN[w];
    end

    // Events are applied last so a same-cycle clear never loses them
    if (c_err | seq_err) begin
      n.irq_stat[IRQ_ERR] = 1'b1;
    end
    if (resp_ev) begin
      n.irq_stat[IRQ_RESP] = 1'b1;
    end
    n.irq = |(n.irq_stat & n.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      s <= RCC_RESET;
    end else begin
      s <= n;
    end
  end

  assign PRDATA     = s.prdata;
  assign PREADY     = s.pready;
  assign PSLVERR    = s.pslverr;
  assign MEAS_OUT   = s.meas_out;
  assign STEP       = s.step;
  assign CAL_FACTOR = s.cal_factor;
  assign OP_PENDING = s.pend;
  assign IRQ        = s.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  sequence zero_passed_s;
    s.seq == SEQ_ZERO && s.ack_seen && !done_s && !s.fail && s.full;
  endsequence

  sequence cal_started_s;
    s.seq == SEQ_CAL && !s.ack_seen;
  endsequence

  capture_conflict_a: assert property (
    cmd_wr && op == OP_REL_AUTO && !qry && prm == PRM_ONCE && s.cfg[CFG_SPEED200]
    |=> s.err_valid && s.err_code == ERR_CONFLICT && $stable(s.ref_val))
    else $error("capture at speed 200 not refused");

  capture_illegal_a: assert property (
    cmd_wr && op == OP_REL_AUTO && !qry && prm == PRM_ON && !win
    |=> s.err_code == ERR_ILLEGAL && $stable(s.ref_val[0]))
    else $error("capture with ON not flagged");

  rel_passthru_a: assert property (
    !s.rel_en[1] |=> s.meas_out[1] == $past(MEAS_IN[1]))
    else $error("measurement altered while relative off");

  reset_clear_a: assert property (
    $rose(RST_B) |-> s.rel_en == 2'b00)
    else $error("relative enable not cleared by reset");

  state_query_a: assert property (
    cmd_wr && op == OP_REL_STATE && qry && !win
    |=> s.resp_valid && s.resp_val == $past(s.rel_en[0]))
    else $error("relative state query answer wrong");

  enable_conflict_a: assert property (
    cmd_wr && op == OP_REL_STATE && !qry && prm == PRM_ON && s.cfg[CFG_SPEED200] && !win
    |=> s.err_code == ERR_CONFLICT && s.rel_en[0] == $past(s.rel_en[0]))
    else $error("relative enable at speed 200 not refused");

  suffix_range_a: assert property (
    cmd_wr && op == OP_CAL_ALL && win && !s.cfg[CFG_DUAL] && s.seq == SEQ_IDLE
    |=> s.seq == SEQ_IDLE ##0 s.err_code == ERR_SUFFIX)
    else $error("suffix 2 accepted on single channel");

  bus_overlap_a: assert property (
    s.pend && cmd_wr && op == OP_REL_STATE && qry |=> s.resp_valid)
    else $error("query not answered during calibration");

  zero_then_cal_a: assert property (
    zero_passed_s |=> cal_started_s ##0 s.step.zero == 1'b0)
    else $error("calibration did not follow zeroing");

  pend_done_a: assert property (
    $fell(s.pend) |-> s.irq_stat[IRQ_DONE] && s.seq == SEQ_IDLE)
    else $error("sequence end not reported");

  zero_fail_a: assert property (
    s.seq == SEQ_ZERO && s.ack_seen && !done_s && s.fail
    |=> s.err_code == ERR_QUEST && s.err_zero && s.seq == SEQ_IDLE)
    else $error("zero failure not reported");

endmodule

`default_nettype wire

/* sim/rcc_engine.sv */
// Behavioural zero/calibration step engine on the far side of the STEP link.
// Assumes the device keeps req high until it has seen done, four-phase.
`default_nettype none

module rcc_engine (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire rcc_pkg::rcc_step_t step,
  input  wire logic               fail_zero,
  input  wire logic               fail_cal,
  input  wire logic [7:0]         delay,
  output logic                    done,
  output logic                    fail,
  output logic      [7:0]         hist
);
  timeunit 1ns;
  timeprecision 1ps;
  import rcc_pkg::*;

  logic       busy;
  logic       fv;
  logic [7:0] cnt;

  ////////////////////////////////////////////////////////////
  // Answer delay+1 cycles after taking req; hist logs {zero,chan} of each step taken.
  // A released fail line shows the inverse, so a stale level cannot pass.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      done <= 1'b0;
      fail <= 1'b0;
      busy <= 1'b0;
      fv   <= 1'b0;
      cnt  <= 8'h00;
      hist <= 8'h00;
    end else if (done) begin
      if (!step.req) begin
        done <= 1'b0;
        busy <= 1'b0;
        fail <= ~fail;
      end
    end else if (busy) begin
      if (cnt == 8'h00) begin
        done <= 1'b1;
        fail <= fv;
      end else begin
        cnt <= cnt - 8'h01;
      end
    end else if (step.req) begin
      busy <= 1'b1;
      cnt  <= delay;
      fv   <= step.zero ? fail_zero : fail_cal;
      hist <= {hist[5:0], step.zero, step.chan};
    end
  end
endmodule

`default_nettype wire

/* sim/rcc_top_test.sv */
// Self-checking bench for rcc_top: APB tasks drive decoded commands.
// Assumes zero wait state APB and the step engine model on the STEP link.
`default_nettype none

module rcc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rcc_pkg::*;

  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, done, fail;
  logic        op_pending, irq, fz, fc, er;
  logic [7:0]  paddr, tbl_factor, cal_factor, dly, hist;
  logic [1:0]  tbl_load;
  logic [31:0] pwdata, prdata, rd;
  rcc_meas_t   meas_in, meas_out;
  rcc_fac_t    ee_factor;
  rcc_step_t   step;
  int          num_errors, cmp_count;

  rcc_top u_dut (.CORE_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .MEAS_IN(meas_in), .MEAS_OUT(meas_out), .TBL_LOAD(tbl_load),
    .TBL_FACTOR(tbl_factor), .EE_FACTOR(ee_factor), .STEP_DONE(done), .STEP_FAIL(fail),
    .STEP(step), .CAL_FACTOR(cal_factor), .OP_PENDING(op_pending), .IRQ(irq));

  rcc_engine u_eng (.clk(clk), .rst_b(rst_b), .step(step), .fail_zero(fz), .fail_cal(fc),
    .delay(dly), .done(done), .fail(fail), .hist(hist));

  ////////////////////////////////////////////////////////////
  // Reporting
  task automatic print_verdict();
    $display("counts: %0d comparisons, %0d mismatches", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic hang(input string n);
    num_errors++;
    $display("mismatch %s expected completion seen timeout", n);
    print_verdict();
  endtask

  ////////////////////////////////////////////////////////////
  // APB master: hold the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) hang("pready");
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd & m);
  endtask

  task automatic cmd(input logic [3:0] op, input logic [1:0] s, input logic [1:0] p,
                     input logic q, input logic [7:0] v);
    wr(OFS_CMD, {8'h00, v, 7'h00, q, p, s, op});
  endtask

  // Fixed settling before the wait: pending rises a cycle after the write
  task automatic wait_idle();
    int i;
    repeat (3) @(posedge clk);
    for (i = 0; i < 400; i++) begin
      @(posedge clk);
      if (op_pending === 1'b0) break;
    end
    if (i == 400) hang("op_pending");
  endtask

  task automatic wait_req();
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (step.req === 1'b1) break;
    end
    if (i == 50) hang("step req");
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_b, psel, penable, pwrite, fz, fc} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    meas_in = {16'h0300, 16'h0100};
    tbl_load = 2'h0;
    tbl_factor = 8'h00;
    ee_factor = {8'h88, 8'h77};
    dly = 8'h01;
    num_errors = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rchk("stat", OFS_STAT, 32'h7, 32'h0);
    rchk("factor", OFS_FACTOR, 32'hFFFF, 32'h6464);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, er);
    $display("test reset done");

    cmd(OP_REL_STATE, 2'h1, PRM_OFF, 1'b1, 8'h00);
    rchk("resp", OFS_RESP, 32'h3, 32'h2);
    cmd(OP_REL_AUTO, 2'h1, PRM_ONCE, 1'b0, 8'h00);
    rchk("ref", OFS_REF, 32'hFFFF, 32'h0100);
    rchk("rel_en", OFS_STAT, 32'h6, 32'h2);
    cmd(OP_REL_STATE, 2'h1, PRM_OFF, 1'b1, 8'h00);
    rchk("resp", OFS_RESP, 32'h3, 32'h3);
    meas_in <= {16'h0300, 16'h0150};
    repeat (3) @(posedge clk);
    chk("meas0", 32'h0050, meas_out[0]);
    chk("meas1", 32'h0300, meas_out[1]);
    cmd(OP_REL_AUTO, 2'h1, PRM_ON, 1'b0, 8'h00);
    rchk("err", OFS_ERR, 32'h8000FFFF, 32'h8000FF20);
    rchk("ref", OFS_REF, 32'hFFFF, 32'h0100);
    cmd(OP_REL_AUTO, 2'h1, PRM_OFF, 1'b1, 8'h00);
    rchk("resp", OFS_RESP, 32'h3, 32'h2);
    cmd(OP_REL_STATE, 2'h1, PRM_OFF, 1'b0, 8'h00);
    repeat (3) @(posedge clk);
    chk("meas0", 32'h0150, meas_out[0]);
    // A reset in mid-run must drop relative mode that was switched on
    cmd(OP_REL_STATE, 2'h2, PRM_ON, 1'b0, 8'h00);
    rchk("rel_en", OFS_STAT, 32'h6, 32'h4);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rchk("rel_en", OFS_STAT, 32'h6, 32'h0);
    $display("test relative done");

    wr(OFS_CFG, 32'h1);
    cmd(OP_REL_AUTO, 2'h1, PRM_ONCE, 1'b0, 8'h00);
    rchk("err", OFS_ERR, 32'h8000FFFF, 32'h8000FF23);
    rchk("rel_en", OFS_STAT, 32'h6, 32'h0);
    cmd(OP_REL_STATE, 2'h2, PRM_ON, 1'b0, 8'h00);
    rchk("err", OFS_ERR, 32'h8000FFFF, 32'h8000FF23);
    rchk("rel_en", OFS_STAT, 32'h6, 32'h0);
    wr(OFS_CFG, 32'h0);
    $display("test speed conflict done");

    // Error event: masked, unmasked, then cleared by writing one
    wr(OFS_IRQ_STAT, 32'h7);
    wr(OFS_IRQ_MASK, 32'h0);
    cmd(OP_REL_AUTO, 2'h1, PRM_ON, 1'b0, 8'h00);
    repeat (3) @(posedge clk);
    chk("irq", 32'h0, irq);
    rchk("irq_stat", OFS_IRQ_STAT, 32'h1, 32'h1);
    wr(OFS_IRQ_MASK, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq", 32'h1, irq);
    wr(OFS_IRQ_STAT, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq", 32'h0, irq);
    $display("test interrupt done");

    cmd(OP_CAL_ALL, 2'h2, PRM_ONCE, 1'b0, 8'h00);
    rchk("err", OFS_ERR, 32'h8000FFFF, 32'h8000FF8E);
    chk("pending", 32'h0, op_pending);
    chk("hist", 32'h0, hist);
    wr(OFS_CFG, 32'h2);
    dly <= 8'h14;
    cmd(OP_CAL_ZERO, 2'h2, PRM_ONCE, 1'b0, 8'h00);
    rchk("pending", OFS_STAT, 32'h1, 32'h1);
    cmd(OP_REL_STATE, 2'h1, PRM_OFF, 1'b1, 8'h00);
    rchk("resp", OFS_RESP, 32'h3, 32'h2);
    wait_idle();
    chk("hist", 32'h3, hist[1:0]);
    rchk("pending", OFS_STAT, 32'h1, 32'h0);
    cmd(OP_CAL_AUTO, 2'h2, PRM_ONCE, 1'b0, 8'h00);
    wait_idle();
    chk("hist", 32'hD, hist[3:0]);
    dly <= 8'h01;
    wr(OFS_IRQ_STAT, 32'h7);
    wr(OFS_IRQ_MASK, 32'h4);
    cmd(OP_CAL_ALL, 2'h1, PRM_ONCE, 1'b1, 8'h00);
    wait_idle();
    chk("hist", 32'h8, hist[3:0]);
    rchk("resp", OFS_RESP, 32'h3, 32'h2);
    chk("irq", 32'h1, irq);
    cmd(OP_CAL_ALL, 2'h1, PRM_ONCE, 1'b0, 8'h00);
    wait_idle();
    rchk("resp", OFS_RESP, 32'h3, 32'h0);
    $display("test sequence done");

    fc <= 1'b1;
    cmd(OP_CAL_ALL, 2'h2, PRM_ONCE, 1'b1, 8'h00);
    wait_idle();
    rchk("resp", OFS_RESP, 32'h3, 32'h3);
    rchk("err", OFS_ERR, 32'h8003FFFF, 32'h8002FF19);
    fc <= 1'b0;
    fz <= 1'b1;
    cmd(OP_CAL_ALL, 2'h1, PRM_ONCE, 1'b1, 8'h00);
    wait_idle();
    rchk("err", OFS_ERR, 32'h8003FFFF, 32'h8001FF19);
    chk("hist", 32'h6, hist[3:0]);
    fz <= 1'b0;
    cmd(OP_CAL_AUTO, 2'h1, PRM_OFF, 1'b0, 8'h00);
    repeat (5) @(posedge clk);
    chk("pending", 32'h0, op_pending);
    chk("hist", 32'h2, hist[1:0]);
    cmd(OP_CAL_AUTO, 2'h1, PRM_ON, 1'b0, 8'h00);
    rchk("err", OFS_ERR, 32'h8000FFFF, 32'h8000FF20);
    $display("test failures done");

    // Factor: the last of manual entry and table load wins
    cmd(OP_RCF, 2'h1, PRM_OFF, 1'b0, 8'h62);
    rchk("factor", OFS_FACTOR, 32'hFFFF, 32'h6462);
    tbl_factor <= 8'h55;
    tbl_load <= 2'h1;
    @(posedge clk);
    tbl_load <= 2'h0;
    rchk("factor", OFS_FACTOR, 32'hFFFF, 32'h6455);
    cmd(OP_RCF, 2'h1, PRM_OFF, 1'b0, 8'h60);
    rchk("factor", OFS_FACTOR, 32'hFFFF, 32'h6460);
    dly <= 8'h14;
    cmd(OP_CAL_AUTO, 2'h1, PRM_ONCE, 1'b0, 8'h00);
    wait_req();
    chk("cal_factor", 32'h60, cal_factor);
    wait_idle();
    wr(OFS_CFG, 32'h6);
    cmd(OP_CAL_AUTO, 2'h1, PRM_ONCE, 1'b0, 8'h00);
    wait_req();
    chk("cal_factor", 32'h77, cal_factor);
    wait_idle();
    $display("test factor done");
    print_verdict();
  end
endmodule

`default_nettype wire
